// ---- rtl/tmr_defines.svh ----
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

// register indices on the plain register port
`define TMR_ADDR_CTRLA 4'h0
`define TMR_ADDR_CTRLB 4'h1
`define TMR_ADDR_COUNT 4'h2
`define TMR_ADDR_CMPA 4'h3
`define TMR_ADDR_CMPB 4'h4
`define TMR_ADDR_CMPC 4'h5
`define TMR_ADDR_CAPTOP 4'h6
`define TMR_ADDR_STATUS 4'h7
`define TMR_ADDR_MASK 4'h8
`define TMR_ADDR_PORTCFG 4'h9

// field positions
`define TMR_ACT_A_MSB 7
`define TMR_ACT_STRIDE 2
`define TMR_MODE_LO_MSB 1
`define TMR_MODE_HI_MSB 4
`define TMR_MODE_HI_LSB 3
`define TMR_CLKSEL_MSB 2
`define TMR_STAT_OVF 0
`define TMR_STAT_MATCH_LSB 1
`define TMR_PORT_VAL_LSB 3

// reset values
`define TMR_CTRLA_RST 8'h00
`define TMR_CTRLB_RST 5'h00
`define TMR_WORD_RST 16'h0000
`define TMR_FLAGS_RST 4'h0
`define TMR_PORTCFG_RST 6'h00

// count limits
`define TMR_BOTTOM 16'h0000
`define TMR_MAX 16'hFFFF
`define TMR_TOP_8BIT 16'h00FF
`define TMR_TOP_9BIT 16'h01FF
`define TMR_TOP_10BIT 16'h03FF

// modes checked for a channel a toggle in pwm; 15 and 9 allow it, 14 never does
`define TMR_MODE_FAST_TOGGLE 4'hF
`define TMR_MODE_DUAL_TOGGLE0 4'h9
`define TMR_MODE_DUAL_TOGGLE1 4'hE

// prescaler selects and their divider masks
`define TMR_CS_STOP 3'h0
`define TMR_CS_DIV1 3'h1
`define TMR_CS_DIV8 3'h2
`define TMR_CS_DIV64 3'h3
`define TMR_CS_DIV256 3'h4
`define TMR_CS_DIV1024 3'h5
`define TMR_MASK_DIV8 10'h007
`define TMR_MASK_DIV64 10'h03F
`define TMR_MASK_DIV256 10'h0FF
`define TMR_MASK_DIV1024 10'h3FF

`endif

// ---- rtl/tmr_out_unit.sv ----
`timescale 1ns/1ps
`include "tmr_defines.svh"
module tmr_out_unit
   import tmr_pkg::*;
#(
   parameter bit IS_CHAN_A = 1'b0
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic tick,
   input tmr_class_t cls,
   input wire logic [3:0] modeSel,
   input wire logic [1:0] action,
   input wire logic match,
   input wire logic atTop,
   input wire logic countUp,
   output logic level,
   output logic connected
);
   logic level_q; // compare output level
   logic level_d;
   logic toggleOk; // toggle action allowed in this mode

   // toggle is open to every channel outside pwm, only to channel a in modes 9 and 15 inside
   always_comb
   begin
      case (cls)
         CLS_FAST: toggleOk = IS_CHAN_A && (modeSel == `TMR_MODE_FAST_TOGGLE);
         CLS_DUAL: toggleOk = IS_CHAN_A && ((modeSel == `TMR_MODE_DUAL_TOGGLE0) ||
                                            (modeSel == `TMR_MODE_DUAL_TOGGLE1));
         default: toggleOk = 1'b1;
      endcase
      connected = (action != 2'b00) && !((action == 2'b01) && !toggleOk);
   end

   // waveform action per family
   always_comb
   begin
      level_d = level_q;
      if (tick && connected)
      begin
         case (cls)
            CLS_NONPWM:
            begin
               if (match)
                  level_d = action[1] ? action[0] : !level_q;
            end
            CLS_FAST:
            begin
               // top action wins over match at top
               if (atTop && action[1])
                  level_d = !action[0];
               else if (match)
                  level_d = action[1] ? action[0] : !level_q;
            end
            CLS_DUAL:
            begin
               if (match)
                  level_d = action[1] ? (countUp ? action[0] : !action[0]) : !level_q;
            end
            // unused family code leaves the level alone
            default: level_d = level_q;
         endcase
      end
   end

   // level register
   always_ff @(posedge clk)
   begin
      if (!nrst)
         level_q <= 1'b0;
      else
         level_q <= level_d;
   end

   assign level = level_q;
endmodule : tmr_out_unit

// ---- rtl/tmr_pkg.sv ----
package tmr_pkg;
   // counting family of the selected mode
   typedef enum logic [1:0] {
      CLS_NONPWM = 2'b00,
      CLS_FAST = 2'b01,
      CLS_DUAL = 2'b10
   } tmr_class_t;
   // point in the count where an update or flag happens
   typedef enum logic [1:0] {
      WH_IMM = 2'b00,
      WH_TOP = 2'b01,
      WH_BOT = 2'b10,
      WH_MAX = 2'b11
   } tmr_when_t;
endpackage : tmr_pkg

// ---- rtl/tmr_prescaler.sv ----
`timescale 1ns/1ps
`include "tmr_defines.svh"
module tmr_prescaler
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [2:0] clkSel,
   output logic tick
);
   logic [9:0] div_q; // free divider, held at zero while stopped
   logic [9:0] div_d;

   // divider advances only while a source is selected
   always_comb
   begin
      div_d = (clkSel == `TMR_CS_STOP) ? 10'h000 : 10'(div_q + 10'h001);
   end

   // one-cycle enable at the selected rate
   always_comb
   begin
      case (clkSel)
         `TMR_CS_STOP: tick = 1'b0;
         `TMR_CS_DIV1: tick = 1'b1;
         `TMR_CS_DIV8: tick = ((div_q & `TMR_MASK_DIV8) == `TMR_MASK_DIV8);
         `TMR_CS_DIV64: tick = ((div_q & `TMR_MASK_DIV64) == `TMR_MASK_DIV64);
         `TMR_CS_DIV256: tick = ((div_q & `TMR_MASK_DIV256) == `TMR_MASK_DIV256);
         `TMR_CS_DIV1024: tick = ((div_q & `TMR_MASK_DIV1024) == `TMR_MASK_DIV1024);
         // external pin clocking is not built here, so it stops the count
         default: tick = 1'b0;
      endcase
   end

   // divider register
   always_ff @(posedge clk)
   begin
      if (!nrst)
         div_q <= 10'h000;
      else
         div_q <= div_d;
   end
endmodule : tmr_prescaler

// ---- rtl/tmr_wave_ctrl.sv ----
`timescale 1ns/1ps
`include "tmr_defines.svh"
module tmr_wave_ctrl
   import tmr_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [3:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [15:0] regRdData,
   output logic [2:0] cmpPinOut,
   output logic [2:0] cmpPinOe,
   output logic [2:0] cmpOverride,
   output logic irq
);
   logic [7:0] ctrlA_q; // output actions and low mode bits
   logic [7:0] ctrlA_d;
   logic [4:0] ctrlB_q; // high mode bits and clock select
   logic [4:0] ctrlB_d;
   logic [15:0] capTop_q; // software-written top for capture modes
   logic [15:0] capTop_d;
   logic [3:0] mask_q; // interrupt mask, same layout as status
   logic [3:0] mask_d;
   logic [5:0] portCfg_q; // pin directions and plain port levels
   logic [5:0] portCfg_d;
   logic [2:0][15:0] cmpBuf_q; // compare values as written
   logic [2:0][15:0] cmpBuf_d;
   logic [2:0][15:0] cmpAct_q; // compare values in use
   logic [2:0][15:0] cmpAct_d;
   logic [15:0] cnt_q; // counter value
   logic [15:0] cnt_d;
   logic dirUp_q; // dual-slope direction
   logic dirUp_d;
   logic [3:0] status_q; // sticky overflow and match flags
   logic [3:0] status_d;
   logic [15:0] rdData_q;
   logic [15:0] rdData_d;
   logic [2:0] pinOut_q;
   logic [2:0] pinOut_d;
   logic [2:0] pinOe_q;
   logic [2:0] pinOe_d;
   logic [2:0] ovr_q;
   logic [2:0] ovr_d;
   logic irq_q;
   logic irq_d;
   logic [3:0] modeSel; // four-bit waveform mode
   tmr_class_t cls;
   tmr_when_t updAt; // when compare values load
   tmr_when_t tovAt; // when overflow flag sets
   logic [15:0] topVal;
   logic tick; // prescaled count enable
   logic atTop;
   logic atBottom;
   logic effUp; // direction seen by the compare units
   logic [2:0] match;
   logic [2:0] lvl;
   logic [2:0] conn;
   logic [3:0] evSet;
   logic [3:0] evClr;

   assign modeSel = {ctrlB_q[`TMR_MODE_HI_MSB:`TMR_MODE_HI_LSB],
                     ctrlA_q[`TMR_MODE_LO_MSB:0]};

   // mode decode
   always_comb
   begin
      unique case (modeSel)
         4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: cls = CLS_DUAL;
         4'h5, 4'h6, 4'h7, 4'hE, 4'hF: cls = CLS_FAST;
         // reserved 13 simply counts like normal mode
         4'h0, 4'h4, 4'hC, 4'hD: cls = CLS_NONPWM;
      endcase
      unique case (modeSel)
         4'h0, 4'hD: topVal = `TMR_MAX;
         4'h1, 4'h5: topVal = `TMR_TOP_8BIT;
         4'h2, 4'h6: topVal = `TMR_TOP_9BIT;
         4'h3, 4'h7: topVal = `TMR_TOP_10BIT;
         4'h4, 4'h9, 4'hB, 4'hF: topVal = cmpAct_q[0];
         4'h8, 4'hA, 4'hC, 4'hE: topVal = capTop_q;
      endcase
      if (cls == CLS_NONPWM)
         updAt = WH_IMM;
      else if ((modeSel == 4'h8) || (modeSel == 4'h9))
         updAt = WH_BOT;
      else
         updAt = WH_TOP;
      if (cls == CLS_NONPWM)
         tovAt = WH_MAX;
      else if (cls == CLS_FAST)
         tovAt = WH_TOP;
      else
         tovAt = WH_BOT;
   end

   assign atTop = (cnt_q == topVal);
   assign atBottom = (cnt_q == `TMR_BOTTOM);
   // the turning points count as the slope being entered
   assign effUp = atBottom ? 1'b1 : (atTop ? 1'b0 : dirUp_q);

   // prescaled enable
   tmr_prescaler uPresc (
      .clk(clk),
      .nrst(nrst),
      .clkSel(ctrlB_q[`TMR_CLKSEL_MSB:0]),
      .tick(tick)
   );

   // one output unit per channel
   for (genvar i = 0; i < 3; i++)
   begin : gChan
      assign match[i] = tick && (cnt_q == cmpAct_q[i]);
      tmr_out_unit #(.IS_CHAN_A(i == 0)) uOut (
         .clk(clk),
         .nrst(nrst),
         .tick(tick),
         .cls(cls),
         .modeSel(modeSel),
         .action(ctrlA_q[`TMR_ACT_A_MSB - `TMR_ACT_STRIDE * i -: 2]),
         .match(match[i]),
         .atTop(atTop),
         .countUp(effUp),
         .level(lvl[i]),
         .connected(conn[i])
      );
   end

   // software-written configuration
   always_comb
   begin
      ctrlA_d = ctrlA_q;
      ctrlB_d = ctrlB_q;
      capTop_d = capTop_q;
      mask_d = mask_q;
      portCfg_d = portCfg_q;
      cmpBuf_d = cmpBuf_q;
      if (regWr)
      begin
         case (regAddr)
            `TMR_ADDR_CTRLA: ctrlA_d = regWrData[7:0];
            `TMR_ADDR_CTRLB: ctrlB_d = regWrData[4:0];
            `TMR_ADDR_CMPA: cmpBuf_d[0] = regWrData;
            `TMR_ADDR_CMPB: cmpBuf_d[1] = regWrData;
            `TMR_ADDR_CMPC: cmpBuf_d[2] = regWrData;
            `TMR_ADDR_CAPTOP: capTop_d = regWrData;
            `TMR_ADDR_MASK: mask_d = regWrData[3:0];
            `TMR_ADDR_PORTCFG: portCfg_d = regWrData[5:0];
            // other addresses hold no configuration
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         ctrlA_q <= `TMR_CTRLA_RST;
         ctrlB_q <= `TMR_CTRLB_RST;
         capTop_q <= `TMR_WORD_RST;
         mask_q <= `TMR_FLAGS_RST;
         portCfg_q <= `TMR_PORTCFG_RST;
         cmpBuf_q <= '0;
      end
      else
      begin
         ctrlA_q <= ctrlA_d;
         ctrlB_q <= ctrlB_d;
         capTop_q <= capTop_d;
         mask_q <= mask_d;
         portCfg_q <= portCfg_d;
         cmpBuf_q <= cmpBuf_d;
      end
   end

   // counting sequence; a software write beats the tick
   always_comb
   begin
      cnt_d = cnt_q;
      dirUp_d = (cls == CLS_DUAL) ? dirUp_q : 1'b1;
      if (tick)
      begin
         if (cls != CLS_DUAL)
            cnt_d = atTop ? `TMR_BOTTOM : 16'(cnt_q + 16'h0001);
         else if (dirUp_q && !atTop)
            cnt_d = 16'(cnt_q + 16'h0001);
         else if (dirUp_q)
         begin
            dirUp_d = 1'b0;
            cnt_d = 16'(cnt_q - 16'h0001);
         end
         else if (!atBottom)
            cnt_d = 16'(cnt_q - 16'h0001);
         else
         begin
            dirUp_d = 1'b1;
            cnt_d = 16'(cnt_q + 16'h0001);
         end
      end
      if (regWr && (regAddr == `TMR_ADDR_COUNT))
         cnt_d = regWrData;
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         cnt_q <= `TMR_WORD_RST;
         dirUp_q <= 1'b1;
      end
      else
      begin
         cnt_q <= cnt_d;
         dirUp_q <= dirUp_d;
      end
   end

   // compare values in use; buffering avoids glitched pwm periods
   always_comb
   begin
      cmpAct_d = cmpAct_q;
      if ((updAt == WH_IMM) ||
          (tick && (updAt == WH_TOP) && atTop) ||
          (tick && (updAt == WH_BOT) && atBottom))
         cmpAct_d = cmpBuf_q;
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
         cmpAct_q <= '0;
      else
         cmpAct_q <= cmpAct_d;
   end

   // sticky flags, write one to clear, a new event beats the clear
   always_comb
   begin
      case (tovAt)
         WH_MAX: evSet[`TMR_STAT_OVF] = tick && (cnt_q == `TMR_MAX);
         WH_TOP: evSet[`TMR_STAT_OVF] = tick && atTop;
         default: evSet[`TMR_STAT_OVF] = tick && atBottom && !dirUp_q;
      endcase
      evSet[3:`TMR_STAT_MATCH_LSB] = match;
      evClr = (regWr && (regAddr == `TMR_ADDR_STATUS)) ? regWrData[3:0] : 4'h0;
      status_d = (status_q & ~evClr) | evSet;
      irq_d = |(status_d & mask_d);
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
         status_q <= `TMR_FLAGS_RST;
      else
         status_q <= status_d;
   end

   // read data stand one cycle, zero otherwise
   always_comb
   begin
      rdData_d = 16'h0000;
      if (regRd)
      begin
         case (regAddr)
            `TMR_ADDR_CTRLA: rdData_d = {8'h00, ctrlA_q};
            `TMR_ADDR_CTRLB: rdData_d = {11'h000, ctrlB_q};
            `TMR_ADDR_COUNT: rdData_d = cnt_q;
            `TMR_ADDR_CMPA: rdData_d = cmpBuf_q[0];
            `TMR_ADDR_CMPB: rdData_d = cmpBuf_q[1];
            `TMR_ADDR_CMPC: rdData_d = cmpBuf_q[2];
            `TMR_ADDR_CAPTOP: rdData_d = capTop_q;
            `TMR_ADDR_STATUS: rdData_d = {12'h000, status_q};
            `TMR_ADDR_MASK: rdData_d = {12'h000, mask_q};
            `TMR_ADDR_PORTCFG: rdData_d = {10'h000, portCfg_q};
            // unmapped reads answer zero
            default: rdData_d = 16'h0000;
         endcase
      end
   end

   // pin drive: compare level when taken over, plain port value otherwise
   always_comb
   begin
      ovr_d = conn;
      pinOut_d = (conn & lvl) | (~conn & portCfg_q[5:`TMR_PORT_VAL_LSB]);
      pinOe_d = portCfg_q[2:0];
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         rdData_q <= 16'h0000;
         ovr_q <= 3'h0;
         pinOut_q <= 3'h0;
         pinOe_q <= 3'h0;
         irq_q <= 1'b0;
      end
      else
      begin
         rdData_q <= rdData_d;
         ovr_q <= ovr_d;
         pinOut_q <= pinOut_d;
         pinOe_q <= pinOe_d;
         irq_q <= irq_d;
      end
   end

   assign regRdData = rdData_q;
   assign cmpPinOut = pinOut_q;
   assign cmpPinOe = pinOe_q;
   assign cmpOverride = ovr_q;
   assign irq = irq_q;

   sequence sFastTop;
      tick && (cls == CLS_FAST) && atTop && !regWr;
   endsequence
   sequence sDualTurnTop;
      tick && (cls == CLS_DUAL) && dirUp_q && atTop && !regWr;
   endsequence

   chk_override_off: assert property (@(posedge clk) disable iff (!nrst)
      (ctrlA_q[7:6] == 2'b00) |=> !cmpOverride[0])
      else $error("channel a pin taken with action off");
   chk_nonpwm_clear: assert property (@(posedge clk) disable iff (!nrst)
      (cls == CLS_NONPWM) && (ctrlA_q[5:4] == 2'b10) && match[1] |=> !lvl[1])
      else $error("non-pwm clear on match missed");
   chk_fast_toggle_gate: assert property (@(posedge clk) disable iff (!nrst)
      (cls == CLS_FAST) && (ctrlA_q[7:6] == 2'b01) && (modeSel != 4'hF) ##1 !regWr
      |-> !cmpOverride[0])
      else $error("fast toggle connected outside mode 15");
   chk_fast_top_set: assert property (@(posedge clk) disable iff (!nrst)
      sFastTop ##0 (ctrlA_q[7:6] == 2'b10) |=> lvl[0] ##1 (pinOut_q[0] || !cmpOverride[0]))
      else $error("non-inverted fast pwm not high after top");
   chk_fast_top_clear: assert property (@(posedge clk) disable iff (!nrst)
      sFastTop ##0 (ctrlA_q[3:2] == 2'b11) |=> !lvl[2])
      else $error("inverted fast pwm not low after top");
   chk_fast_top_wins: assert property (@(posedge clk) disable iff (!nrst)
      sFastTop ##0 match[1] && (ctrlA_q[5:4] == 2'b10) |=> lvl[1])
      else $error("match at top overrode top action");
   chk_dual_toggle_gate: assert property (@(posedge clk) disable iff (!nrst)
      (cls == CLS_DUAL) && (ctrlA_q[5:4] == 2'b01) |-> !conn[1])
      else $error("channel b toggle connected in dual slope");
   chk_dual_up_clear: assert property (@(posedge clk) disable iff (!nrst)
      (cls == CLS_DUAL) && (ctrlA_q[7:6] == 2'b10) && match[0] && effUp |=> !lvl[0])
      else $error("dual slope up match did not clear");
   chk_dual_down_clear: assert property (@(posedge clk) disable iff (!nrst)
      (cls == CLS_DUAL) && (ctrlA_q[3:2] == 2'b11) && match[2] && !effUp |=> !lvl[2])
      else $error("inverted dual slope down match did not clear");
   chk_mode_low_bits: assert property (@(posedge clk) disable iff (!nrst)
      regWr && (regAddr == `TMR_ADDR_CTRLA) |=> (modeSel[1:0] == $past(regWrData[1:0])))
      else $error("mode low bits not taken from control a");
   chk_dual_turn: assert property (@(posedge clk) disable iff (!nrst)
      sDualTurnTop |=> !dirUp_q && (cnt_q == 16'($past(cnt_q) - 16'h0001)))
      else $error("dual slope did not turn at top");
   chk_fast_wrap: assert property (@(posedge clk) disable iff (!nrst)
      sFastTop |=> (cnt_q == `TMR_BOTTOM) && status_q[`TMR_STAT_OVF])
      else $error("fast pwm did not wrap and flag at top");
   chk_pfc_bottom_flag: assert property (@(posedge clk) disable iff (!nrst)
      tick && ((modeSel == 4'h8) || (modeSel == 4'h9)) && atBottom && !dirUp_q
      |=> status_q[`TMR_STAT_OVF] && (cmpAct_q == $past(cmpBuf_q)))
      else $error("bottom load or flag missing");
   chk_max_flag: assert property (@(posedge clk) disable iff (!nrst)
      tick && (cls == CLS_NONPWM) && (cnt_q == `TMR_MAX) && !regWr
      |=> status_q[`TMR_STAT_OVF] && (cnt_q == `TMR_BOTTOM))
      else $error("overflow at max missing");
   chk_mode_high_bits: assert property (@(posedge clk) disable iff (!nrst)
      regWr && (regAddr == `TMR_ADDR_CTRLB) |=> (modeSel[3:2] == $past(regWrData[4:3])))
      else $error("mode high bits not taken from control b");
   chk_dual_bottom_low: assert property (@(posedge clk) disable iff (!nrst)
      (cls == CLS_DUAL) && (ctrlA_q[7:6] == 2'b10) && match[0] && atBottom |=> !lvl[0])
      else $error("dual compare at bottom not low");
   chk_reset_clear: assert property (@(posedge clk) disable iff (!nrst)
      $rose(nrst) |-> (ctrlA_q == `TMR_CTRLA_RST) && (cmpOverride == 3'h0))
      else $error("control a not clear after reset");
endmodule : tmr_wave_ctrl

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`include "tmr_defines.svh"
module tb_top;
   // control a, control b, expected ownership
   // no row selects the reserved mode 13
   typedef struct packed {logic [7:0] a; logic [4:0] b; logic [2:0] own;} tmr_row_t;
   tmr_row_t rows [11] = '{
      '{8'h54, 5'h00, 3'h7}, '{8'h57, 5'h18, 3'h1}, '{8'h56, 5'h18, 3'h0},
      '{8'h57, 5'h08, 3'h0}, '{8'h55, 5'h10, 3'h1}, '{8'h54, 5'h10, 3'h0},
      '{8'h57, 5'h10, 3'h0}, '{8'hB9, 5'h00, 3'h7}, '{8'h21, 5'h08, 3'h2},
      '{8'h0C, 5'h18, 3'h4}, '{8'h00, 5'h00, 3'h0}};
   // action in 2:1, pin level after the match in 0
   logic [2:0] acts [4] = '{3'b111, 3'b100, 3'b011, 3'b010};
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [3:0] regAddr = 4'h0;
   logic [15:0] regWrData = 16'h0000;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [15:0] regRdData;
   logic [2:0] cmpPinOut, cmpPinOe, cmpOverride, pinLevel;
   logic irq;
   logic [15:0] rd;
   int fails = 0;
   int compares = 0;
   int hi, lo;

   // 20 MHz clock
   always #25 clk = ~clk;

   tmr_wave_ctrl i_tmr_wave_ctrl (.clk(clk), .nrst(nrst), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .cmpPinOut(cmpPinOut), .cmpPinOe(cmpPinOe), .cmpOverride(cmpOverride), .irq(irq));
   tmr_pin_load i_tmr_pin_load (.pinOut(cmpPinOut), .pinOe(cmpPinOe), .pinLevel(pinLevel));

   task automatic give_verdict();
      $display("fails %0d compares %0d", fails, compares);
      if (fails == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // strobe dropped with a spare edge, so calls never collide
   task automatic wrReg(input logic [3:0] a, input logic [15:0] d);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
      @(posedge clk);
   endtask : wrReg

   // data stand only in the cycle after the strobe
   task automatic rdReg(input logic [3:0] a, output logic [15:0] d);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = regRdData;
      @(posedge clk);
   endtask : rdReg

   // bounded wait on pin a, sampled mid-cycle
   task automatic waitPin(input logic lvl, output int n);
      n = 0;
      while (pinLevel[0] !== lvl && n < 3000)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= 3000)
      begin
         fails++;
         give_verdict();
      end
   endtask : waitPin

   // one full period of pin a: high and low widths in cycles
   task automatic pulse(input logic [15:0] expHi, input logic [15:0] expLo);
      waitPin(1'b0, hi);
      waitPin(1'b1, hi);
      waitPin(1'b0, hi);
      waitPin(1'b1, lo);
      chk(hi[15:0], expHi);
      chk(lo[15:0], expLo);
      @(posedge clk);
   endtask : pulse

   // pin a must not move for two whole periods
   task automatic steady(input logic lvl);
      int bad;
      bad = 0;
      repeat (600) @(negedge clk);
      repeat (1100)
      begin
         @(negedge clk);
         bad += (pinLevel[0] !== lvl);
      end
      chk(bad[15:0], 16'h0000);
      @(posedge clk);
   endtask : steady

   initial
   begin
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rdReg(`TMR_ADDR_CTRLA, rd);
      chk(rd, 16'h0000);
      chk({13'h0, cmpOverride}, 16'h0000);
      wrReg(4'hF, 16'hFFFF);
      rdReg(4'hF, rd);
      chk(rd, 16'h0000);
      foreach (rows[i])
      begin
         wrReg(`TMR_ADDR_CTRLB, {11'h0, rows[i].b});
         wrReg(`TMR_ADDR_CTRLA, {8'h0, rows[i].a});
         rdReg(`TMR_ADDR_CTRLA, rd);
         chk(rd, {8'h0, rows[i].a});
         rdReg(`TMR_ADDR_CTRLB, rd);
         chk(rd, {11'h0, rows[i].b});
         chk({13'h0, cmpOverride}, {13'h0, rows[i].own});
      end
      wrReg(`TMR_ADDR_PORTCFG, 16'h0007);
      // enable register lands on the spare edge, so look one edge later
      @(posedge clk);
      chk({13'h0, cmpPinOe}, 16'h0007);
      wrReg(`TMR_ADDR_CMPA, 16'h1000);
      wrReg(`TMR_ADDR_CTRLB, 16'h0001);
      // match reached 16 ticks after the counter write
      foreach (acts[i])
      begin
         wrReg(`TMR_ADDR_CTRLA, {8'h0, acts[i][2:1], 6'h00});
         wrReg(`TMR_ADDR_COUNT, 16'h0FF0);
         repeat (40) @(negedge clk);
         chk({15'h0, pinLevel[0]}, {15'h0, acts[i][0]});
         @(posedge clk);
      end
      wrReg(`TMR_ADDR_CMPA, 16'h0040);
      wrReg(`TMR_ADDR_CTRLB, 16'h0009);
      wrReg(`TMR_ADDR_CTRLA, 16'h0081);
      // counter is far above the 8-bit top here; restart it below top
      wrReg(`TMR_ADDR_COUNT, 16'h0000);
      pulse(16'h0041, 16'h00BF);
      wrReg(`TMR_ADDR_CTRLA, 16'h00C1);
      pulse(16'h00BF, 16'h0041);
      wrReg(`TMR_ADDR_CMPA, 16'h00FF);
      wrReg(`TMR_ADDR_CTRLA, 16'h0081);
      steady(1'b1);
      wrReg(`TMR_ADDR_CMPA, 16'h0040);
      wrReg(`TMR_ADDR_CTRLB, 16'h0001);
      pulse(16'h0080, 16'h017E);
      wrReg(`TMR_ADDR_CTRLA, 16'h00C1);
      pulse(16'h017E, 16'h0080);
      wrReg(`TMR_ADDR_CMPA, 16'h0000);
      wrReg(`TMR_ADDR_CTRLA, 16'h0081);
      steady(1'b0);
      wrReg(`TMR_ADDR_CMPA, 16'h00FF);
      steady(1'b1);
      // overflow flag, then mask, then clear by writing one
      wrReg(`TMR_ADDR_MASK, 16'h0000);
      rdReg(`TMR_ADDR_STATUS, rd);
      chk(rd & 16'h0001, 16'h0001);
      chk({15'h0, irq}, 16'h0000);
      wrReg(`TMR_ADDR_MASK, 16'h0001);
      rdReg(`TMR_ADDR_STATUS, rd);
      chk({15'h0, irq}, 16'h0001);
      wrReg(`TMR_ADDR_CTRLB, 16'h0000);
      wrReg(`TMR_ADDR_STATUS, 16'h000F);
      rdReg(`TMR_ADDR_STATUS, rd);
      chk(rd, 16'h0000);
      chk({15'h0, irq}, 16'h0000);
      give_verdict();
   end
endmodule : tb_top

// ---- test/tmr_pin_load.sv ----
`timescale 1ns/1ps
// far side: pins loaded by a motor driver with pull-downs
module tmr_pin_load
(
   input wire logic [2:0] pinOut,
   input wire logic [2:0] pinOe,
   output logic [2:0] pinLevel
);
   // an undriven pin falls to its pull-down
   assign pinLevel = pinOut & pinOe;
endmodule : tmr_pin_load
